/* verilog/mpm_poll_map.sv */
`timescale 1ns/1ns
module mpm_poll_map (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cfg_clear,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_slave,
    input wire logic [7:0] cfg_func,
    input wire logic [15:0] cfg_start,
    input wire logic [6:0] cfg_count,
    output logic cfg_err,
    output logic [7:0] cfg_num,
    output logic poll_req,
    output logic [7:0] poll_slave,
    output logic [7:0] poll_func,
    output logic [15:0] poll_start,
    output logic [6:0] poll_count,
    output logic [7:0] poll_def,
    input wire logic poll_data_valid,
    input wire logic [15:0] poll_data,
    input wire logic poll_done,
    input wire logic [1:0] poll_result,
    input wire logic [7:0] poll_exc_code,
    output logic img_wr,
    output logic [1:0] img_area,
    output logic [15:0] img_addr,
    output logic [15:0] img_data,
    input wire logic cw_req,
    input wire logic [1:0] cw_area,
    input wire logic [15:0] cw_addr,
    input wire logic [15:0] cw_data,
    output logic cw_busy,
    output logic cw_miss,
    output logic fwd_req,
    output logic [7:0] fwd_slave,
    output logic [7:0] fwd_func,
    output logic [15:0] fwd_addr,
    output logic [15:0] fwd_data,
    input wire logic sr_req,
    input wire logic [7:0] sr_func,
    input wire logic [15:0] sr_addr,
    input wire logic [7:0] sr_count,
    output logic sr_busy,
    output logic sr_valid,
    output logic [15:0] sr_data,
    output logic sr_last,
    output logic sr_exc,
    output logic [7:0] sr_exc_code
);
    import mpm_pkg::*;
    `include "mpm_consts.svh"
    mpm_top_st_t s_q;
    mpm_top_st_t s_d;
    logic [7:0] prev_def_q;

    // ==========================================
    // Next state: config, scan, write forwarding
    always_comb
    begin
        mpm_def_t cd;
        mpm_def_t sd;
        logic [7:0] ci;
        ci = (s_q.idx < s_q.num) ? s_q.idx : 8'h00;
        cd = s_q.defs[s_q.idx];
        sd = s_q.defs[s_q.sidx];
        s_d = s_q;
        s_d.cfg_err = 1'b0;
        s_d.poll_req = 1'b0;
        s_d.img_wr = 1'b0;
        s_d.fwd_req = 1'b0;
        s_d.cw_miss = 1'b0;
        s_d.st_wr = 1'b0;
        // Definitions append in listing order; bad ones are refused whole
        if (cfg_clear)
        begin
            s_d.num = 8'h00;
        end
        else if (cfg_wr)
        begin
            if (s_q.num == 8'(`MPM_MAX_DEFS) || cfg_func < `MPM_FC_RD_COIL
                || cfg_func > `MPM_FC_RD_IREG
                || cfg_count == 7'h00 || cfg_count > `MPM_MAX_REGS)
            begin
                s_d.cfg_err = 1'b1;
            end
            else
            begin
                s_d.defs[s_q.num] = '{slave: cfg_slave, area: 2'(cfg_func - 8'h01),
                    start: cfg_start, count: cfg_count};
                s_d.num = s_q.num + 8'h01;
            end
        end
        // One write held at a time; busy refuses the next
        if (cw_req && !s_q.cw_pend)
        begin
            s_d.cw_pend = 1'b1;
            s_d.cw_area = cw_area;
            s_d.cw_addr = cw_addr;
            s_d.cw_data = cw_data;
        end
        case (s_q.state)
            ST_IDLE:
            begin
                if (s_q.cw_pend && s_q.num != 8'h00)
                begin
                    s_d.state = ST_SEARCH;
                    s_d.sidx = 8'h00;
                    s_d.srun = '0;
                end
                else if (s_q.cw_pend)
                begin
                    s_d.cw_pend = 1'b0;
                    s_d.cw_miss = 1'b1;
                end
                else if (s_q.num != 8'h00)
                begin
                    cd = s_q.defs[ci];
                    s_d.idx = ci;
                    s_d.poll_req = 1'b1;
                    s_d.poll_slave = cd.slave;
                    s_d.poll_func = {6'h00, cd.area} + 8'h01;
                    s_d.poll_start = cd.start;
                    s_d.poll_count = cd.count;
                    s_d.poll_def = ci;
                    s_d.base = (ci == 8'h00) ? 16'h0000 : s_q.run[cd.area];
                    s_d.wcnt = 7'h00;
                    s_d.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // Words past the definition's count are dropped
                if (poll_data_valid && s_q.wcnt < cd.count)
                begin
                    s_d.img_wr = 1'b1;
                    s_d.img_area = cd.area;
                    s_d.img_addr = s_q.base + 16'(s_q.wcnt);
                    s_d.img_data = poll_data;
                    s_d.wcnt = s_q.wcnt + 7'h01;
                end
                if (poll_done)
                begin
                    s_d.st_wr = 1'b1;
                    s_d.st_idx = s_q.idx;
                    if (poll_result == `MPM_RES_GOOD)
                    begin
                        s_d.st_word = `MPM_STAT_GOOD;
                    end
                    else if (poll_result == `MPM_RES_TIMEOUT)
                    begin
                        s_d.st_word = `MPM_STAT_TIMEOUT;
                    end
                    else
                    begin
                        s_d.st_word = {`MPM_STAT_EXC_TAG, s_q.poll_func[3:0],
                            poll_exc_code};
                    end
                    // Next block of this type starts right after this one
                    s_d.run[cd.area] = s_q.base + 16'(cd.count);
                    if (s_q.idx + 8'h01 >= s_q.num)
                    begin
                        s_d.idx = 8'h00;
                        s_d.run = '0;
                    end
                    else
                    begin
                        s_d.idx = s_q.idx + 8'h01;
                    end
                    s_d.state = ST_IDLE;
                end
            end
            ST_SEARCH:
            begin
                // Walks the list one definition a cycle; slow but needs no adders per entry
                if (s_q.sidx >= s_q.num || (s_q.cw_area != `MPM_AREA_COIL
                    && s_q.cw_area != `MPM_AREA_HOLD))
                begin
                    s_d.cw_pend = 1'b0;
                    s_d.cw_miss = 1'b1;
                    s_d.state = ST_IDLE;
                end
                else if (sd.area == s_q.cw_area && s_q.cw_addr >= s_q.srun[sd.area]
                    && s_q.cw_addr < s_q.srun[sd.area] + 16'(sd.count))
                begin
                    s_d.fwd_req = 1'b1;
                    s_d.fwd_slave = sd.slave;
                    s_d.fwd_func = (sd.area == `MPM_AREA_COIL) ? `MPM_FC_WR_COIL
                        : `MPM_FC_WR_REG;
                    s_d.fwd_addr = sd.start + (s_q.cw_addr - s_q.srun[sd.area]);
                    if (sd.area == `MPM_AREA_COIL)
                    begin
                        s_d.fwd_data = (s_q.cw_data != 16'h0000) ? `MPM_COIL_ON : 16'h0000;
                    end
                    else
                    begin
                        s_d.fwd_data = s_q.cw_data;
                    end
                    s_d.cw_pend = 1'b0;
                    s_d.state = ST_IDLE;
                end
                else
                begin
                    s_d.srun[sd.area] = s_q.srun[sd.area] + 16'(sd.count);
                    s_d.sidx = s_q.sidx + 8'h01;
                end
            end
            default:
            begin
                s_d.state = ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Status words, read by clients with function 04
    mpm_status_table u_stat (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en(s_q.st_wr),
        .wr_idx(s_q.st_idx),
        .wr_word(s_q.st_word),
        .rd_req(sr_req),
        .rd_func(sr_func),
        .rd_addr(sr_addr),
        .rd_count(sr_count),
        .rd_busy(sr_busy),
        .rd_valid(sr_valid),
        .rd_data(sr_data),
        .rd_last(sr_last),
        .rd_exc(sr_exc),
        .rd_exc_code(sr_exc_code)
    );

    assign cfg_err = s_q.cfg_err;
    assign cfg_num = s_q.num;
    assign poll_req = s_q.poll_req;
    assign poll_slave = s_q.poll_slave;
    assign poll_func = s_q.poll_func;
    assign poll_start = s_q.poll_start;
    assign poll_count = s_q.poll_count;
    assign poll_def = s_q.poll_def;
    assign img_wr = s_q.img_wr;
    assign img_area = s_q.img_area;
    assign img_addr = s_q.img_addr;
    assign img_data = s_q.img_data;
    assign cw_busy = s_q.cw_pend;
    assign cw_miss = s_q.cw_miss;
    assign fwd_req = s_q.fwd_req;
    assign fwd_slave = s_q.fwd_slave;
    assign fwd_func = s_q.fwd_func;
    assign fwd_addr = s_q.fwd_addr;
    assign fwd_data = s_q.fwd_data;

    // ==========================================
    // Checks
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prev_def_q <= 8'hff;
        end
        else if (poll_req)
        begin
            prev_def_q <= poll_def;
        end
    end

    poll_order_a: assert property (@(posedge core_clk) disable iff (rst)
        poll_req |-> (poll_def == 8'h00 || poll_def == prev_def_q + 8'h01))
        else $error("poll skipped a definition");

    first_base_a: assert property (@(posedge core_clk) disable iff (rst)
        poll_req && poll_def == 8'h00 |-> s_q.base == 16'h0000)
        else $error("first definition not at area start");

    pack_step_a: assert property (@(posedge core_clk) disable iff (rst)
        img_wr && s_q.state == ST_WAIT ##1 img_wr && s_q.state == ST_WAIT
            |-> img_addr == $past(img_addr) + 16'h0001)
        else $error("image words not consecutive");

    poll_func_a: assert property (@(posedge core_clk) disable iff (rst)
        poll_req |-> poll_func >= `MPM_FC_RD_COIL && poll_func <= `MPM_FC_RD_IREG)
        else $error("poll uses a non-read function");

    poll_count_a: assert property (@(posedge core_clk) disable iff (rst)
        poll_req |-> poll_count != 7'h00 && poll_count <= `MPM_MAX_REGS)
        else $error("poll count out of range");

    status_upd_a: assert property (@(posedge core_clk) disable iff (rst)
        poll_done && s_q.state == ST_WAIT |=> s_q.st_wr && s_q.st_idx == $past(s_q.idx))
        else $error("status not written at poll completion");

    timeout_word_a: assert property (@(posedge core_clk) disable iff (rst)
        poll_done && s_q.state == ST_WAIT && poll_result == `MPM_RES_TIMEOUT
            |=> s_q.st_word == `MPM_STAT_TIMEOUT)
        else $error("timeout status not all ones");

    fwd_write_a: assert property (@(posedge core_clk) disable iff (rst)
        fwd_req |-> $past(cw_busy) && !cw_busy
            && (fwd_func == `MPM_FC_WR_COIL || fwd_func == `MPM_FC_WR_REG))
        else $error("forward without a held client write");
endmodule // mpm_poll_map

/* shared/mpm_consts.svh */
`ifndef MPM_CONSTS_SVH
`define MPM_CONSTS_SVH
// Notes on behaviour
// - Polls are issued in configured definition order, wrapping round as a scan.
// - Successive definitions of one type pack into consecutive local addresses.
// - Each type has its own local area; its first definition starts at offset zero.
// - A client write to a mapped output address is forwarded to the slave.
// - One status word per definition, in order, from address 39600 to 39849.
// - Status words are read with function 04, up to 126 per request.
// - Status reads zero when good and all ones after a timeout.
// - Exception status is 8 in top nibble, function nibble, exception code byte.
// - Exception codes 01, 02, 03: bad function, bad address, bad value.
// - Exception code 04: response would exceed the maximum frame size.
// - Definitions only accept the four read functions 01 to 04.
// - Each definition reads between 1 and 125 remote registers.

// ==========================================
// Sizes
`define MPM_MAX_DEFS 250
`define MPM_MAX_REGS 7'h7d
`define MPM_MAX_STAT_RD 8'h7e

// ==========================================
// Status area, first address 39600
`define MPM_STAT_BASE 16'h9ab0
`define MPM_STAT_GOOD 16'h0000
`define MPM_STAT_TIMEOUT 16'hffff
`define MPM_STAT_EXC_TAG 4'h8

// ==========================================
// Function and exception codes
`define MPM_FC_RD_COIL 8'h01
`define MPM_FC_RD_IREG 8'h04
`define MPM_FC_WR_COIL 8'h05
`define MPM_FC_WR_REG 8'h06
`define MPM_COIL_ON 16'hff00
`define MPM_EXC_ILL_FUNC 8'h01
`define MPM_EXC_ILL_ADDR 8'h02
`define MPM_EXC_ILL_VAL 8'h03
`define MPM_EXC_ILL_LEN 8'h04

// ==========================================
// Local areas, area code is function code minus one
`define MPM_AREA_COIL 2'h0
`define MPM_AREA_HOLD 2'h2

// ==========================================
// Poll outcomes
`define MPM_RES_GOOD 2'h0
`define MPM_RES_TIMEOUT 2'h1
`define MPM_RES_EXC 2'h2
`endif

/* shared/mpm_pkg.sv */
package mpm_pkg;
`include "mpm_consts.svh"

    // One polling definition
    typedef struct packed {
        logic [7:0] slave;
        logic [1:0] area;
        logic [15:0] start;
        logic [6:0] count;
    } mpm_def_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEARCH} mpm_state_t;

    // Whole state of the scanner
    typedef struct packed {
        mpm_def_t [`MPM_MAX_DEFS-1:0] defs;
        mpm_state_t state;
        logic [7:0] num;
        logic [7:0] idx;
        logic [3:0][15:0] run;
        logic [3:0][15:0] srun;
        logic [7:0] sidx;
        logic [6:0] wcnt;
        logic [15:0] base;
        logic cw_pend;
        logic [1:0] cw_area;
        logic [15:0] cw_addr;
        logic [15:0] cw_data;
        logic cfg_err;
        logic poll_req;
        logic [7:0] poll_slave;
        logic [7:0] poll_func;
        logic [15:0] poll_start;
        logic [6:0] poll_count;
        logic [7:0] poll_def;
        logic img_wr;
        logic [1:0] img_area;
        logic [15:0] img_addr;
        logic [15:0] img_data;
        logic fwd_req;
        logic [7:0] fwd_slave;
        logic [7:0] fwd_func;
        logic [15:0] fwd_addr;
        logic [15:0] fwd_data;
        logic cw_miss;
        logic st_wr;
        logic [7:0] st_idx;
        logic [15:0] st_word;
    } mpm_top_st_t;

    // Whole state of the status table
    typedef struct packed {
        logic [`MPM_MAX_DEFS-1:0][15:0] words;
        logic active;
        logic [7:0] ridx;
        logic [7:0] left;
        logic rd_valid;
        logic [15:0] rd_data;
        logic rd_last;
        logic rd_exc;
        logic [7:0] rd_exc_code;
    } mpm_stat_st_t;
endpackage

/* verilog/mpm_status_table.sv */
`timescale 1ns/1ns
module mpm_status_table (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_idx,
    input wire logic [15:0] wr_word,
    input wire logic rd_req,
    input wire logic [7:0] rd_func,
    input wire logic [15:0] rd_addr,
    input wire logic [7:0] rd_count,
    output logic rd_busy,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic rd_last,
    output logic rd_exc,
    output logic [7:0] rd_exc_code
);
    import mpm_pkg::*;
    `include "mpm_consts.svh"
    mpm_stat_st_t s_q;
    mpm_stat_st_t s_d;
    logic [16:0] end_addr;
    logic [7:0] burst_q;

    // ==========================================
    // Next state: table update and read burst
    always_comb
    begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        s_d.rd_last = 1'b0;
        s_d.rd_exc = 1'b0;
        end_addr = {1'b0, rd_addr} + {9'h000, rd_count};
        // A write lands before a later read; same-cycle read sees the old word
        if (wr_en)
        begin
            s_d.words[wr_idx] = wr_word;
        end
        if (s_q.active)
        begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data = s_q.words[s_q.ridx];
            s_d.rd_last = (s_q.left == 8'h01);
            s_d.ridx = s_q.ridx + 8'h01;
            s_d.left = s_q.left - 8'h01;
            s_d.active = (s_q.left != 8'h01);
        end
        else if (rd_req)
        begin
            if (rd_func != `MPM_FC_RD_IREG)
            begin
                s_d.rd_exc = 1'b1;
                s_d.rd_exc_code = `MPM_EXC_ILL_FUNC;
            end
            else if (rd_count > `MPM_MAX_STAT_RD)
            begin
                s_d.rd_exc = 1'b1;
                s_d.rd_exc_code = `MPM_EXC_ILL_LEN;
            end
            else if (rd_count == 8'h00)
            begin
                s_d.rd_exc = 1'b1;
                s_d.rd_exc_code = `MPM_EXC_ILL_VAL;
            end
            else if (rd_addr < `MPM_STAT_BASE
                || end_addr > {1'b0, `MPM_STAT_BASE} + 17'(`MPM_MAX_DEFS))
            begin
                s_d.rd_exc = 1'b1;
                s_d.rd_exc_code = `MPM_EXC_ILL_ADDR;
            end
            else
            begin
                s_d.active = 1'b1;
                s_d.ridx = 8'(rd_addr - `MPM_STAT_BASE);
                s_d.left = rd_count;
            end
        end
    end

    // ==========================================
    // State register; table starts as all good
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rd_busy = s_q.active;
    assign rd_valid = s_q.rd_valid;
    assign rd_data = s_q.rd_data;
    assign rd_last = s_q.rd_last;
    assign rd_exc = s_q.rd_exc;
    assign rd_exc_code = s_q.rd_exc_code;

    // ==========================================
    // Checks: burst length counter for the read limit
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            burst_q <= 8'h00;
        end
        else
        begin
            burst_q <= rd_valid ? (rd_last ? 8'h00 : burst_q + 8'h01) : burst_q;
        end
    end

    burst_len_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_valid |-> burst_q < `MPM_MAX_STAT_RD)
        else $error("status burst longer than 126 words");

    stat_code_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_valid |-> (rd_data == `MPM_STAT_GOOD || rd_data == `MPM_STAT_TIMEOUT
            || rd_data[15:12] == `MPM_STAT_EXC_TAG))
        else $error("status word has an unknown form");

    exc_range_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_exc |-> (rd_exc_code >= `MPM_EXC_ILL_FUNC && rd_exc_code <= `MPM_EXC_ILL_LEN))
        else $error("status read exception code out of range");

    bad_func_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_req && !rd_busy && rd_func != `MPM_FC_RD_IREG
            |=> rd_exc && rd_exc_code == `MPM_EXC_ILL_FUNC && !rd_busy)
        else $error("status read with wrong function not refused");

    good_read_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_req && !rd_busy && rd_func == `MPM_FC_RD_IREG && rd_count == 8'h01
            && rd_addr == `MPM_STAT_BASE |=> ##1 rd_valid && rd_last)
        else $error("single status read did not return one word");
endmodule // mpm_status_table

/* verif/mpm_slave_model.sv */
`timescale 1ns/1ns
`include "mpm_consts.svh"
// ==========================================
// Remote slave model
module mpm_slave_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic poll_req,
    input wire logic [6:0] poll_count,
    input wire logic [7:0] poll_def,
    output logic poll_data_valid,
    output logic [15:0] poll_data,
    output logic poll_done,
    output logic [1:0] poll_result,
    output logic [7:0] poll_exc_code
);
    int n;
    int i;
    logic [7:0] d;
    // One poll at a time; later definitions answer more slowly
    initial
    begin
        {poll_data_valid, poll_done, poll_result, poll_exc_code} = '0;
        poll_data = 16'h5a5a;
        forever
        begin
            // Look after the edge, once the request flop has settled
            @(posedge core_clk);
            #5;
            if (poll_req === 1'b1 && rst === 1'b0)
            begin
                d = poll_def;
                n = (d > 8'h02) ? 0 : int'(poll_count); // Silent or refusing slaves send no data
                repeat (4 + 2 * d) @(posedge core_clk);
                // Valid stays up across a burst of words
                for (i = 0; i < n; i++)
                begin
                    #5 poll_data_valid = 1'b1;
                    poll_data = {d, 8'(i)};
                    @(posedge core_clk);
                end
                #5 poll_data_valid = 1'b0;
                poll_data = ~poll_data; // Line is not left at the last word
                poll_done = 1'b1;
                poll_result = (d == 8'h03) ? `MPM_RES_TIMEOUT
                    : (d == 8'h04) ? `MPM_RES_EXC : `MPM_RES_GOOD;
                poll_exc_code = `MPM_EXC_ILL_ADDR;
                @(posedge core_clk);
                #5 poll_done = 1'b0;
                poll_exc_code = 8'ha5;
            end
        end
    end
endmodule // mpm_slave_model

/* verif/tb_top.sv */
`timescale 1ns/1ns
// ==========================================
// Bench top
module tb_top;
    logic core_clk, rst, cfg_clear, cfg_wr, cfg_err, poll_req, poll_data_valid, poll_done;
    logic img_wr, cw_req, cw_busy, cw_miss, fwd_req, sr_req, sr_busy, sr_valid, sr_last, sr_exc;
    logic [7:0] cfg_slave, cfg_func, cfg_num, poll_slave, poll_func, poll_def, poll_exc_code;
    logic [7:0] fwd_slave, fwd_func, sr_func, sr_count, sr_exc_code, got_code;
    logic [15:0] cfg_start, poll_start, poll_data, img_addr, img_data, cw_addr, cw_data;
    logic [15:0] fwd_addr, fwd_data, sr_addr, sr_data;
    logic [6:0] cfg_count, poll_count;
    logic [1:0] poll_result, img_area, cw_area;
    logic got_exc;
    int mismatches = 0, n_checks = 0, cyc = 0;
    logic [46:0] defs_q[$];
    logic [33:0] img_q[$];
    logic [15:0] rd_q[$];

    mpm_poll_map dut_u (.core_clk, .rst, .cfg_clear, .cfg_wr, .cfg_slave, .cfg_func, .cfg_start,
        .cfg_count, .cfg_err, .cfg_num, .poll_req, .poll_slave, .poll_func, .poll_start,
        .poll_count, .poll_def, .poll_data_valid, .poll_data, .poll_done, .poll_result,
        .poll_exc_code, .img_wr, .img_area, .img_addr, .img_data, .cw_req, .cw_area, .cw_addr,
        .cw_data, .cw_busy, .cw_miss, .fwd_req, .fwd_slave, .fwd_func, .fwd_addr, .fwd_data,
        .sr_req, .sr_func, .sr_addr, .sr_count, .sr_busy, .sr_valid, .sr_data, .sr_last,
        .sr_exc, .sr_exc_code);
    mpm_slave_model slave_u (.core_clk, .rst, .poll_req, .poll_count, .poll_def,
        .poll_data_valid, .poll_data, .poll_done, .poll_result, .poll_exc_code);

    // ==========================================
    // Clock, monitors and hang guard
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Record polls and image writes at the falling edge, where they have settled
    always @(negedge core_clk)
    begin
        cyc <= cyc + 1;
        if (poll_req === 1'b1)
            defs_q.push_back({poll_slave, poll_func, poll_start, poll_count, poll_def});
        if (img_wr === 1'b1) img_q.push_back({img_area, img_addr, img_data});
        if (cyc == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    // ==========================================
    // Shared tasks
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cfg(input [7:0] s, input [7:0] f, input [15:0] a, input [6:0] c, input logic e);
        @(posedge core_clk);
        #5 {cfg_wr, cfg_slave, cfg_func, cfg_start, cfg_count} = {1'b1, s, f, a, c};
        @(posedge core_clk);
        #5 cfg_wr = 1'b0;
        chk(cfg_err, e);
    endtask
    task sr(input [7:0] f, input [15:0] a, input [7:0] c);
        rd_q.delete();
        {got_exc, got_code} = '0;
        @(posedge core_clk);
        #5 {sr_req, sr_func, sr_addr, sr_count} = {1'b1, f, a, c};
        @(posedge core_clk);
        #5 sr_req = 1'b0;
        // A refusal stands only in the cycle after the request, so look before waiting
        repeat (200)
        begin
            if (sr_exc === 1'b1) {got_exc, got_code} = {1'b1, sr_exc_code};
            if (sr_valid === 1'b1) rd_q.push_back(sr_data);
            if (sr_exc === 1'b1 || sr_last === 1'b1) break;
            @(posedge core_clk);
            #5;
        end
    endtask
    task cw(input [1:0] ar, input [15:0] a, input [15:0] d, input [49:0] e);
        @(posedge core_clk);
        #5 {cw_req, cw_area, cw_addr, cw_data} = {1'b1, ar, a, d};
        @(posedge core_clk);
        #5 cw_req = 1'b0;
        chk(cw_busy, 1'b1);
        repeat (300)
        begin
            @(posedge core_clk);
            #5;
            if (fwd_req === 1'b1 || cw_miss === 1'b1) break;
        end
        chk({cw_miss, fwd_req, fwd_slave, fwd_func, fwd_addr, fwd_data}, e);
    endtask

    // ==========================================
    // Scenarios
    task t_config;
        @(posedge core_clk);
        #5 cfg_clear = 1'b1;
        @(posedge core_clk);
        #5 cfg_clear = 1'b0;
        cfg(8'h11, 8'h04, 16'h0010, 7'h02, 1'b0);
        cfg(8'h22, 8'h03, 16'h01c4, 7'h01, 1'b0);
        cfg(8'h33, 8'h04, 16'h0000, 7'h03, 1'b0);
        cfg(8'h44, 8'h01, 16'h0130, 7'h01, 1'b0);
        cfg(8'h55, 8'h03, 16'h0200, 7'h01, 1'b0);
        cfg(8'h66, 8'h05, 16'h0000, 7'h01, 1'b1);
        cfg(8'h66, 8'h04, 16'h0000, 7'h00, 1'b1);
        cfg(8'h66, 8'h04, 16'h0000, 7'h7e, 1'b1);
        chk(cfg_num, 8'h05);
    endtask
    task t_scan;
        logic [33:0] ex[7];
        logic [38:0] ep[5];
        ex = '{{2'h3, 16'h0, 16'h0000}, {2'h3, 16'h1, 16'h0001}, {2'h2, 16'h0, 16'h0100},
            {2'h3, 16'h2, 16'h0200}, {2'h3, 16'h3, 16'h0201}, {2'h3, 16'h4, 16'h0202},
            {2'h3, 16'h0, 16'h0000}};
        // Poll fields as configured: slave, function, remote start, count
        ep = '{{8'h11, 8'h04, 16'h0010, 7'h02}, {8'h22, 8'h03, 16'h01c4, 7'h01},
            {8'h33, 8'h04, 16'h0000, 7'h03}, {8'h44, 8'h01, 16'h0130, 7'h01},
            {8'h55, 8'h03, 16'h0200, 7'h01}};
        repeat (2000) if (defs_q.size() < 6 || img_q.size() < 7) @(posedge core_clk);
        for (int i = 0; i < 6; i++) chk(defs_q[i], {ep[i % 5], 8'(i % 5)});
        for (int i = 0; i < 7; i++) chk(img_q[i], ex[i]);
    endtask
    task t_status;
        logic [15:0] st[5];
        logic [7:0] fn[4];
        logic [7:0] ct[4];
        logic [7:0] ec[4];
        logic [15:0] ad[4];
        st = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h8302};
        fn = '{8'h03, 8'h04, 8'h04, 8'h04};
        ct = '{8'h01, 8'h7f, 8'h00, 8'h03};
        ad = '{16'h9ab0, 16'h9ab0, 16'h9ab0, 16'h9ba8};
        ec = '{8'h01, 8'h04, 8'h03, 8'h02};
        sr(8'h04, 16'h9ab0, 8'h05);
        chk(rd_q.size(), 5);
        for (int i = 0; i < 5; i++) chk(rd_q[i], st[i]);
        sr(8'h04, 16'h9ab0, 8'h7e);
        chk(rd_q.size(), 126);
        sr(8'h04, 16'h9ba9, 8'h01);
        chk({got_exc, rd_q.size()}, 1);
        sr(8'h04, 16'h9ab0, 8'h01);
        chk({got_exc, rd_q.size()}, 1);
        for (int i = 0; i < 4; i++)
        begin
            sr(fn[i], ad[i], ct[i]);
            chk({got_exc, got_code}, {1'b1, ec[i]});
        end
    endtask
    task t_write;
        // Expected: miss, forward, slave, function, remote address, data
        cw(2'h2, 16'h0000, 16'h1234, {10'h122, 8'h06, 32'h01c41234});
        cw(2'h0, 16'h0000, 16'h0007, {10'h144, 8'h05, 32'h0130ff00});
        cw(2'h2, 16'h0001, 16'h00aa, {10'h155, 8'h06, 32'h020000aa});
        cw(2'h2, 16'h0002, 16'h0001, {10'h255, 8'h06, 32'h020000aa});
    endtask

    task give_verdict;
        $display("Checks made %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {rst, cfg_clear, cfg_wr, cfg_slave, cfg_func, cfg_start, cfg_count} = {1'b1, 41'h0};
        {cw_req, cw_area, cw_addr, cw_data, sr_req, sr_func, sr_addr, sr_count} = '0;
        repeat (20) @(posedge core_clk);
        #5 rst = 1'b0;
        chk({cfg_num, poll_req, sr_busy}, 0);
        t_config;
        t_scan;
        t_status;
        t_write;
        give_verdict();
    end
endmodule // tb_top
